// ---- hw/mirg_regs.vh ----
// Register map, field layout and lookup constants of the motion config bank
`ifndef MIRG_REGS_VH
`define MIRG_REGS_VH

`define MIRG_ADDR_X_LIMIT    7'h07
`define MIRG_ADDR_Y_LIMIT    7'h08
`define MIRG_ADDR_Z_LIMIT    7'h09
`define MIRG_ADDR_DURATION   7'h0A
`define MIRG_ADDR_HP_REF     7'h0B
`define MIRG_ADDR_ROUTING    7'h0C
`define MIRG_ADDR_IDENTITY   7'h0F
`define MIRG_ADDR_GYRO_CTRL1 7'h10
`define MIRG_ADDR_GYRO_CTRL2 7'h11

`define MIRG_RST_BYTE        8'h00
`define MIRG_RST_COUNT       7'h00
`define MIRG_RST_BIT         1'b0
`define MIRG_ZERO_BYTE       8'h00
`define MIRG_ONE_COUNT       7'h01

// Duration register fields
`define MIRG_DUR_WAIT        7
`define MIRG_DUR_CNT_HI      6
`define MIRG_DUR_CNT_LO      0

// Routing register bit positions
`define MIRG_RT_GYRO_EVT     7
`define MIRG_RT_ACCEL_EVT    6
`define MIRG_RT_FIFO_FIVE    5
`define MIRG_RT_FIFO_OVR     4
`define MIRG_RT_FIFO_THS     3
`define MIRG_RT_BOOT         2
`define MIRG_RT_GYRO_DRDY    1
`define MIRG_RT_ACCEL_DRDY   0

// Gyro control 1 fields
`define MIRG_C1_RATE_HI      7
`define MIRG_C1_RATE_LO      5
`define MIRG_C1_RANGE_HI     4
`define MIRG_C1_RANGE_LO     3
`define MIRG_C1_BW_HI        1
`define MIRG_C1_BW_LO        0

// Gyro control 2 fields
`define MIRG_C2_INT_HI       3
`define MIRG_C2_INT_LO       2
`define MIRG_C2_OUT_HI       1
`define MIRG_C2_OUT_LO       0

// Rate codes and output rates in tenths of a hertz
`define MIRG_RATE_OFF        3'h0
`define MIRG_RATE_14         3'h1
`define MIRG_RATE_59         3'h2
`define MIRG_RATE_119        3'h3
`define MIRG_RATE_238        3'h4
`define MIRG_RATE_476        3'h5
`define MIRG_RATE_952        3'h6
`define MIRG_TENTHS_14       14'd149
`define MIRG_TENTHS_59       14'd595
`define MIRG_TENTHS_119      14'd1190
`define MIRG_TENTHS_238      14'd2380
`define MIRG_TENTHS_476      14'd4760
`define MIRG_TENTHS_952      14'd9520
`define MIRG_TENTHS_NONE     14'd0

// Full-scale codes and spans in dps
`define MIRG_RANGE_245       2'h0
`define MIRG_RANGE_500       2'h1
`define MIRG_RANGE_NA        2'h2
`define MIRG_RANGE_2000      2'h3
`define MIRG_DPS_245         12'd245
`define MIRG_DPS_500         12'd500
`define MIRG_DPS_2000        12'd2000
`define MIRG_DPS_NONE        12'd0

// Bandwidth codes
`define MIRG_BW_0            2'h0
`define MIRG_BW_1            2'h1
`define MIRG_BW_2            2'h2

// Filter cutoffs in hertz
`define MIRG_HZ_NONE         8'd0
`define MIRG_HZ_5            8'd5
`define MIRG_HZ_14           8'd14
`define MIRG_HZ_16           8'd16
`define MIRG_HZ_19           8'd19
`define MIRG_HZ_21           8'd21
`define MIRG_HZ_28           8'd28
`define MIRG_HZ_29           8'd29
`define MIRG_HZ_31           8'd31
`define MIRG_HZ_33           8'd33
`define MIRG_HZ_38           8'd38
`define MIRG_HZ_40           8'd40
`define MIRG_HZ_57           8'd57
`define MIRG_HZ_58           8'd58
`define MIRG_HZ_63           8'd63
`define MIRG_HZ_76           8'd76
`define MIRG_HZ_78           8'd78
`define MIRG_HZ_100          8'd100

`endif

// ---- hw/mirg_accel_event.v ----
// Accelerometer threshold events, axis combination and duration filter
`timescale 1ns/1ps
`default_nettype none
`include "mirg_regs.vh"
module mirg_accel_event (
    // Clock and reset
    input  wire        clk,
    input  wire        nrst,
    // Samples and limits, X in low byte
    input  wire        sampleValid,
    input  wire [23:0] sampleXyz,
    input  wire [23:0] limitXyz,
    // Configuration
    input  wire [5:0]  axisEnable,
    input  wire        combineAnd,
    input  wire        exitWait,
    input  wire [6:0]  eventCount,
    // Filtered event
    output reg         eventActive_q
);
    wire [5:0] hit;
    wire       anyEnabled;
    wire       rawEvent;
    reg  [6:0] count_q;

    // Bit 2k is low event, bit 2k+1 high event of axis k
    genvar k;
    generate
        for (k = 0; k < 3; k = k + 1) begin : gAxis
            assign hit[2*k+1] = axisEnable[2*k+1] &&
                (sampleXyz[8*k+7:8*k] > limitXyz[8*k+7:8*k]);
            assign hit[2*k]   = axisEnable[2*k] &&
                (sampleXyz[8*k+7:8*k] < limitXyz[8*k+7:8*k]);
        end
    endgenerate

    assign anyEnabled = |axisEnable;
    // AND of the enabled events only; nothing enabled means no event
    assign rawEvent = combineAnd ? (anyEnabled && ((hit | ~axisEnable) == 6'h3F))
                                 : (|hit);

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            eventActive_q <= `MIRG_RST_BIT;
            count_q       <= `MIRG_RST_COUNT;
        end else if (sampleValid) begin
            if (rawEvent == eventActive_q) begin
                count_q <= `MIRG_RST_COUNT;
            end else if (eventActive_q && !exitWait) begin
                eventActive_q <= 1'b0;
                count_q       <= `MIRG_RST_COUNT;
            end else if (count_q >= eventCount) begin
                eventActive_q <= rawEvent;
                count_q       <= `MIRG_RST_COUNT;
            end else begin
                count_q <= count_q + `MIRG_ONE_COUNT;
            end
        end
    end
endmodule
`default_nettype wire

// ---- hw/mirg_gyro_decode.v ----
// Gyro rate, full-scale and filter cutoff decoding
`timescale 1ns/1ps
`default_nettype none
`include "mirg_regs.vh"
module mirg_gyro_decode (
    // Clock and reset
    input  wire        clk,
    input  wire        nrst,
    // Codes
    input  wire [2:0]  rateCode,
    input  wire [1:0]  rangeCode,
    input  wire [1:0]  bwCode,
    // Decoded values
    output reg  [13:0] rateTenths_q,
    output reg  [11:0] rangeDps_q,
    output reg         rangeValid_q,
    output reg  [7:0]  firstLowpassHz_q,
    output reg  [7:0]  secondLowpassHz_q
);
    reg [13:0] rate_d;
    reg [11:0] dps_d;
    reg [7:0]  lp1_d;
    reg [7:0]  lp2_d;

    always @* begin
        rate_d = `MIRG_TENTHS_NONE;
        lp1_d  = `MIRG_HZ_NONE;
        lp2_d  = `MIRG_HZ_NONE;
        case (rateCode)
            `MIRG_RATE_14: begin
                rate_d = `MIRG_TENTHS_14;
                lp1_d  = `MIRG_HZ_5;
                lp2_d  = `MIRG_HZ_NONE;
            end
            `MIRG_RATE_59: begin
                rate_d = `MIRG_TENTHS_59;
                lp1_d  = `MIRG_HZ_19;
                lp2_d  = `MIRG_HZ_16;
            end
            `MIRG_RATE_119: begin
                rate_d = `MIRG_TENTHS_119;
                lp1_d  = `MIRG_HZ_38;
                lp2_d  = (bwCode == `MIRG_BW_0) ? `MIRG_HZ_14 : `MIRG_HZ_31;
            end
            `MIRG_RATE_238: begin
                rate_d = `MIRG_TENTHS_238;
                lp1_d  = `MIRG_HZ_76;
                case (bwCode)
                    `MIRG_BW_0: lp2_d = `MIRG_HZ_14;
                    `MIRG_BW_1: lp2_d = `MIRG_HZ_29;
                    `MIRG_BW_2: lp2_d = `MIRG_HZ_63;
                    default:    lp2_d = `MIRG_HZ_78;
                endcase
            end
            `MIRG_RATE_476: begin
                rate_d = `MIRG_TENTHS_476;
                lp1_d  = `MIRG_HZ_100;
                case (bwCode)
                    `MIRG_BW_0: lp2_d = `MIRG_HZ_21;
                    `MIRG_BW_1: lp2_d = `MIRG_HZ_28;
                    `MIRG_BW_2: lp2_d = `MIRG_HZ_57;
                    default:    lp2_d = `MIRG_HZ_100;
                endcase
            end
            `MIRG_RATE_952: begin
                rate_d = `MIRG_TENTHS_952;
                lp1_d  = `MIRG_HZ_100;
                case (bwCode)
                    `MIRG_BW_0: lp2_d = `MIRG_HZ_33;
                    `MIRG_BW_1: lp2_d = `MIRG_HZ_40;
                    `MIRG_BW_2: lp2_d = `MIRG_HZ_58;
                    default:    lp2_d = `MIRG_HZ_100;
                endcase
            end
            default: rate_d = `MIRG_TENTHS_NONE;
        endcase
    end

    always @* begin
        case (rangeCode)
            `MIRG_RANGE_245:  dps_d = `MIRG_DPS_245;
            `MIRG_RANGE_500:  dps_d = `MIRG_DPS_500;
            `MIRG_RANGE_2000: dps_d = `MIRG_DPS_2000;
            default:          dps_d = `MIRG_DPS_NONE;
        endcase
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rateTenths_q      <= `MIRG_TENTHS_NONE;
            rangeDps_q        <= `MIRG_DPS_245;
            rangeValid_q      <= 1'b1;
            firstLowpassHz_q  <= `MIRG_HZ_NONE;
            secondLowpassHz_q <= `MIRG_HZ_NONE;
        end else begin
            rateTenths_q      <= rate_d;
            rangeDps_q        <= dps_d;
            rangeValid_q      <= (rangeCode != `MIRG_RANGE_NA);
            firstLowpassHz_q  <= lp1_d;
            secondLowpassHz_q <= lp2_d;
        end
    end
endmodule
`default_nettype wire

// ---- hw/mirg_regs_top.v ----
// Motion interrupt and gyro configuration register bank, top level
//
// Contract
// - Three 8-bit read/write accel thresholds for X, Y, Z, reset to zero.
// - Seven-bit accel duration: samples a condition must persist to enter or exit.
// - Wait bit set: exit after duration samples; clear: exit at once.
// - Eight-bit read/write gyro high-pass reference, reset zero, fed to filter.
// - Gyro and accel event sources reach pin only while routed; reset unrouted.
// - FIFO five-sample, overrun and threshold events each reach pin when enabled.
// - Boot status reaches pin when its bit is set, independent of data-ready.
// - Accel and gyro data-ready reach pin only with own enable bits.
// - Three-bit gyro rate code decodes to power-down, six rates, unavailable.
// - Gyro rate code is common output rate when both sensors active.
// - Gyro range code: 245, 500, 2000 dps; code 10 unsupported; resets 00.
// - Two-bit bandwidth code, reset 00, picks second low-pass cutoff with rate.
// - First low-pass cutoff follows rate: 5, 19, 38, 76, 100, 100 Hz.
// - Second low-pass cutoff depends on both rate and bandwidth codes for rate codes 3 to 6.
// - Gyro control 2 holds interrupt path select above output path select.
// - Enabled axis high or low event fires above or below its threshold.
// - Enabled axis events combine by OR when bit is 0, AND when 1.
`timescale 1ns/1ps
`default_nettype none
`include "mirg_regs.vh"
module mirg_regs_top #(
    // Identity value is arbitrary
    parameter [7:0] IDENTITY_VALUE = 8'hA5
) (
    // Clock and reset
    input  wire        clk,
    input  wire        nrst,
    // Register access from the serial interface
    input  wire [6:0]  regAddr,
    input  wire        regWrEn,
    input  wire [7:0]  regWrData,
    input  wire        regRdEn,
    output reg  [7:0]  regRdData_q,
    // Accelerometer samples and event configuration
    input  wire        accelSampleValid,
    input  wire [7:0]  accelX,
    input  wire [7:0]  accelY,
    input  wire [7:0]  accelZ,
    input  wire [5:0]  accelAxisEnable,
    input  wire        accelEventCombine,
    // Interrupt sources
    input  wire        gyroEventIrq,
    input  wire        fifoFiveSamples,
    input  wire        fifoOverrun,
    input  wire        fifoThreshold,
    input  wire        bootStatus,
    input  wire        gyroDataReady,
    input  wire        accelDataReady,
    // Sensor activity
    input  wire        accelActive,
    input  wire        gyroActive,
    // Interrupt pin
    output reg         intPin_q,
    // Accelerometer configuration out
    output wire [7:0]  accelXLimit,
    output wire [7:0]  accelYLimit,
    output wire [7:0]  accelZLimit,
    output wire        accelExitWait,
    output wire [6:0]  accelEventCount,
    output wire        accelEventActive,
    // Gyro configuration out
    output wire [7:0]  gyroHighpassReference,
    output wire [2:0]  gyroRateCode,
    output wire [1:0]  gyroRangeCode,
    output wire [1:0]  gyroBandwidthCode,
    output wire [1:0]  gyroIntSelect,
    output wire [1:0]  gyroOutSelect,
    // Shared output rate
    output reg  [2:0]  commonRateCode_q,
    output reg         commonRateValid_q,
    // Decoded gyro settings
    output wire [13:0] gyroRateTenthsHz,
    output wire [11:0] gyroRangeDps,
    output wire        gyroRangeValid,
    output wire [7:0]  firstLowpassStageHz,
    output wire [7:0]  secondLowpassStageHz
);
    reg  [7:0] xLimit_q;
    reg  [7:0] yLimit_q;
    reg  [7:0] zLimit_q;
    reg  [7:0] duration_q;
    reg  [7:0] hpRef_q;
    reg  [7:0] routing_q;
    reg  [2:0] rate_q;
    reg  [1:0] range_q;
    reg  [1:0] bw_q;
    reg  [3:0] pathSel_q;
    reg  [7:0] rdData_d;
    wire [7:0] ctrl1View;
    wire [7:0] ctrl2View;
    wire [7:0] sourceVec;

    // Register writes; reserved bits are not stored
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            xLimit_q   <= `MIRG_RST_BYTE;
            yLimit_q   <= `MIRG_RST_BYTE;
            zLimit_q   <= `MIRG_RST_BYTE;
            duration_q <= `MIRG_RST_BYTE;
            hpRef_q    <= `MIRG_RST_BYTE;
            routing_q  <= `MIRG_RST_BYTE;
            rate_q     <= `MIRG_RATE_OFF;
            range_q    <= `MIRG_RANGE_245;
            bw_q       <= `MIRG_BW_0;
            pathSel_q  <= 4'h0;
        end else if (regWrEn) begin
            if (regAddr == `MIRG_ADDR_X_LIMIT) begin
                xLimit_q <= regWrData;
            end else if (regAddr == `MIRG_ADDR_Y_LIMIT) begin
                yLimit_q <= regWrData;
            end else if (regAddr == `MIRG_ADDR_Z_LIMIT) begin
                zLimit_q <= regWrData;
            end else if (regAddr == `MIRG_ADDR_DURATION) begin
                duration_q <= regWrData;
            end else if (regAddr == `MIRG_ADDR_HP_REF) begin
                hpRef_q <= regWrData;
            end else if (regAddr == `MIRG_ADDR_ROUTING) begin
                routing_q <= regWrData;
            end else if (regAddr == `MIRG_ADDR_GYRO_CTRL1) begin
                rate_q  <= regWrData[`MIRG_C1_RATE_HI:`MIRG_C1_RATE_LO];
                range_q <= regWrData[`MIRG_C1_RANGE_HI:`MIRG_C1_RANGE_LO];
                bw_q    <= regWrData[`MIRG_C1_BW_HI:`MIRG_C1_BW_LO];
            end else if (regAddr == `MIRG_ADDR_GYRO_CTRL2) begin
                pathSel_q <= regWrData[`MIRG_C2_INT_HI:`MIRG_C2_OUT_LO];
            end
        end
    end

    // Reserved positions read back as zero
    assign ctrl1View = {rate_q, range_q, 1'b0, bw_q};
    assign ctrl2View = {4'h0, pathSel_q};

    // Read decode; unmapped addresses return zero
    always @* begin
        if (regAddr == `MIRG_ADDR_X_LIMIT) begin
            rdData_d = xLimit_q;
        end else if (regAddr == `MIRG_ADDR_Y_LIMIT) begin
            rdData_d = yLimit_q;
        end else if (regAddr == `MIRG_ADDR_Z_LIMIT) begin
            rdData_d = zLimit_q;
        end else if (regAddr == `MIRG_ADDR_DURATION) begin
            rdData_d = duration_q;
        end else if (regAddr == `MIRG_ADDR_HP_REF) begin
            rdData_d = hpRef_q;
        end else if (regAddr == `MIRG_ADDR_ROUTING) begin
            rdData_d = routing_q;
        end else if (regAddr == `MIRG_ADDR_IDENTITY) begin
            rdData_d = IDENTITY_VALUE;
        end else if (regAddr == `MIRG_ADDR_GYRO_CTRL1) begin
            rdData_d = ctrl1View;
        end else if (regAddr == `MIRG_ADDR_GYRO_CTRL2) begin
            rdData_d = ctrl2View;
        end else begin
            rdData_d = `MIRG_ZERO_BYTE;
        end
    end

    // Read data holds until the next read
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            regRdData_q <= `MIRG_RST_BYTE;
        end else if (regRdEn) begin
            regRdData_q <= rdData_d;
        end
    end

    // Configuration fields driven straight from storage
    assign accelXLimit           = xLimit_q;
    assign accelYLimit           = yLimit_q;
    assign accelZLimit           = zLimit_q;
    assign accelExitWait         = duration_q[`MIRG_DUR_WAIT];
    assign accelEventCount       = duration_q[`MIRG_DUR_CNT_HI:`MIRG_DUR_CNT_LO];
    assign gyroHighpassReference = hpRef_q;
    assign gyroRateCode          = rate_q;
    assign gyroRangeCode         = range_q;
    assign gyroBandwidthCode     = bw_q;
    assign gyroIntSelect         = pathSel_q[3:2];
    assign gyroOutSelect         = pathSel_q[1:0];

    mirg_accel_event uAccelEvent (
        .clk           (clk),
        .nrst          (nrst),
        .sampleValid   (accelSampleValid),
        .sampleXyz     ({accelZ, accelY, accelX}),
        .limitXyz      ({zLimit_q, yLimit_q, xLimit_q}),
        .axisEnable    (accelAxisEnable),
        .combineAnd    (accelEventCombine),
        .exitWait      (duration_q[`MIRG_DUR_WAIT]),
        .eventCount    (duration_q[`MIRG_DUR_CNT_HI:`MIRG_DUR_CNT_LO]),
        .eventActive_q (accelEventActive)
    );

    mirg_gyro_decode uGyroDecode (
        .clk               (clk),
        .nrst              (nrst),
        .rateCode          (rate_q),
        .rangeCode         (range_q),
        .bwCode            (bw_q),
        .rateTenths_q      (gyroRateTenthsHz),
        .rangeDps_q        (gyroRangeDps),
        .rangeValid_q      (gyroRangeValid),
        .firstLowpassHz_q  (firstLowpassStageHz),
        .secondLowpassHz_q (secondLowpassStageHz)
    );

    // Sources in routing bit order
    assign sourceVec[`MIRG_RT_GYRO_EVT]   = gyroEventIrq;
    assign sourceVec[`MIRG_RT_ACCEL_EVT]  = accelEventActive;
    assign sourceVec[`MIRG_RT_FIFO_FIVE]  = fifoFiveSamples;
    assign sourceVec[`MIRG_RT_FIFO_OVR]   = fifoOverrun;
    assign sourceVec[`MIRG_RT_FIFO_THS]   = fifoThreshold;
    assign sourceVec[`MIRG_RT_BOOT]       = bootStatus;
    assign sourceVec[`MIRG_RT_GYRO_DRDY]  = gyroDataReady;
    assign sourceVec[`MIRG_RT_ACCEL_DRDY] = accelDataReady;

    // Pin and shared rate outputs
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            intPin_q          <= `MIRG_RST_BIT;
            commonRateCode_q  <= `MIRG_RATE_OFF;
            commonRateValid_q <= `MIRG_RST_BIT;
        end else begin
            intPin_q          <= |(sourceVec & routing_q);
            commonRateValid_q <= accelActive && gyroActive;
            if (accelActive && gyroActive) begin
                commonRateCode_q <= rate_q;
            end else begin
                commonRateCode_q <= `MIRG_RATE_OFF;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verification/mirg_regs_asserts.sv ----
// Concurrent checks on the register bank ports
`timescale 1ns/1ps
`default_nettype none
module mirg_regs_asserts #(
    parameter [7:0] IDENTITY_VALUE = 8'hA5
) (
    // Clock and reset
    input wire logic        clk, nrst,
    // Register port
    input wire logic [6:0]  regAddr,
    input wire logic        regWrEn, regRdEn,
    input wire logic [7:0]  regWrData, regRdData_q, accelXLimit,
    // Gyro rate and decode
    input wire logic        accelActive, gyroActive, gyroRangeValid,
    input wire logic [2:0]  gyroRateCode, commonRateCode_q,
    input wire logic [1:0]  gyroRangeCode,
    input wire logic [7:0]  firstLowpassStageHz, secondLowpassStageHz
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    x_write_a: assert property (
        regWrEn && regAddr == 7'h07 |=> accelXLimit == $past(regWrData))
        else $error("X limit write lost");
    ident_read_a: assert property (
        regRdEn && regAddr == 7'h0F |=> regRdData_q == IDENTITY_VALUE)
        else $error("identity read wrong");
    hole_read_a: assert property (
        regRdEn && (regAddr == 7'h0D || regAddr == 7'h0E) |=> regRdData_q == 8'h00)
        else $error("hole read not zero");
    read_hold_a: assert property (!regRdEn |=> $stable(regRdData_q))
        else $error("read data moved");
    common_rate_a: assert property (
        accelActive && gyroActive |=> commonRateCode_q == $past(gyroRateCode))
        else $error("common rate not gyro rate");
    solo_rate_a: assert property (
        !(accelActive && gyroActive) |=> commonRateCode_q == 3'h0)
        else $error("common rate not zero");
    range_gap_a: assert property (gyroRangeCode == 2'h2 |=> !gyroRangeValid)
        else $error("unsupported range marked valid");
    lpf_first_a: assert property (
        gyroRateCode == 3'h4 |=> firstLowpassStageHz == 8'h4C)
        else $error("first cutoff wrong");
    lpf_second_a: assert property (
        gyroRateCode == 3'h2 |=> secondLowpassStageHz == 8'h10)
        else $error("second cutoff wrong");
endmodule
bind mirg_regs_top mirg_regs_asserts #(.IDENTITY_VALUE(IDENTITY_VALUE)) chk (
    .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regWrData(regWrData), .regRdData_q(regRdData_q), .accelXLimit(accelXLimit),
    .accelActive(accelActive), .gyroActive(gyroActive), .gyroRangeValid(gyroRangeValid),
    .gyroRateCode(gyroRateCode), .commonRateCode_q(commonRateCode_q),
    .gyroRangeCode(gyroRangeCode), .firstLowpassStageHz(firstLowpassStageHz),
    .secondLowpassStageHz(secondLowpassStageHz));
`default_nettype wire

// ---- verification/mirg_host_model.sv ----
// Host side of the register port: byte writes and reads
`timescale 1ns/1ps
`default_nettype none
module mirg_host_model (
    // Clock
    input  wire logic       clk,
    // Register port
    output var  logic [6:0] regAddr,
    output var  logic       regWrEn,
    output var  logic [7:0] regWrData,
    output var  logic       regRdEn,
    input  wire logic [7:0] regRdData_q
);
    initial begin
        regAddr = 7'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        regRdEn = 1'b0;
    end
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        if (a == 7'h10)
            d[2] = 1'b0;
        if (a == 7'h11)
            d[7:4] = 4'h0;
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
        regWrData <= ~d;
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1;
        d = regRdData_q;
    endtask
endmodule
`default_nettype wire

// ---- verification/tb_mirg_regs_top.sv ----
// Self-checking bench for the motion config register bank
`timescale 1ns/1ps
`default_nettype none
module tb_mirg_regs_top;
    localparam logic [7:0] ID = 8'h3C; // Arbitrary identity value
    localparam logic [0:7][7:0] LP1 = 64'h000513264C646400;
    localparam logic [0:7][13:0] TEN = {14'h0, 14'h95, 14'h253, 14'h4A6, 14'h94C, 14'h1298,
        14'h2530, 14'h0};
    localparam logic [0:3][11:0] DPS = 48'h0F51F40007D0;
    localparam logic [0:31][7:0] LP2 = {64'h0, 32'h10101010, 32'h0E1F1F1F,
        32'h0E1D3F4E, 32'h151C3964, 32'h21283A64, 32'h0};
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        sampleValid = 1'b0;
    logic [7:0]  accX = 8'h00;
    logic [7:0]  accY = 8'h00;
    logic [5:0]  axisEn = 6'h00;
    logic        combineAnd = 1'b0;
    logic [7:0]  src = 8'h00;
    logic        accOn = 1'b0;
    logic        gyrOn = 1'b0;
    logic [7:0]  rdData;
    wire  [6:0]  regAddr;
    wire  [7:0]  regWrData, regRdData_q, lp1, lp2, xLimit;
    wire         regWrEn, regRdEn, intPin, evtActive, rangeValid, rateOk;
    wire  [42:0] fld;
    wire  [2:0]  commonRate;
    wire  [13:0] tenths;
    wire  [11:0] dps;
    int          err_total = 0;
    int          checks = 0;
    int          cycles = 0;

    initial forever #20 clk = ~clk;

    mirg_host_model host (.clk(clk), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData_q(regRdData_q));

    mirg_regs_top #(.IDENTITY_VALUE(ID)) dut (.clk(clk), .nrst(nrst), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData_q(regRdData_q),
        .accelSampleValid(sampleValid), .accelX(accX), .accelY(accY), .accelZ(8'h00),
        .accelAxisEnable(axisEn), .accelEventCombine(combineAnd), .gyroEventIrq(src[7]),
        .fifoFiveSamples(src[5]), .fifoOverrun(src[4]), .fifoThreshold(src[3]),
        .bootStatus(src[2]), .gyroDataReady(src[1]), .accelDataReady(src[0]),
        .accelActive(accOn), .gyroActive(gyrOn), .intPin_q(intPin), .accelXLimit(xLimit),
        .accelYLimit(fld[42:35]), .accelZLimit(fld[34:27]), .accelExitWait(fld[26]),
        .accelEventCount(fld[25:19]), .accelEventActive(evtActive),
        .gyroHighpassReference(fld[18:11]), .gyroRateCode(fld[10:8]), .gyroRangeCode(fld[7:6]),
        .gyroBandwidthCode(fld[5:4]), .gyroIntSelect(fld[3:2]), .gyroOutSelect(fld[1:0]),
        .commonRateCode_q(commonRate), .commonRateValid_q(rateOk), .gyroRateTenthsHz(tenths),
        .gyroRangeDps(dps), .gyroRangeValid(rangeValid), .firstLowpassStageHz(lp1),
        .secondLowpassStageHz(lp2));

    task automatic chk(input string what, input logic [42:0] exp, input logic [42:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim;
        if (err_total == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic smp(input logic [7:0] x, input logic [7:0] y);
        @(posedge clk);
        sampleValid <= 1'b1;
        accX <= x;
        accY <= y;
        @(posedge clk);
        sampleValid <= 1'b0;
        #1;
    endtask

    task automatic t_reset;
        for (int a = 7; a <= 17; a++) begin
            host.rd(a[6:0], rdData);
            chk("reset read", (a == 15) ? ID : 8'h00, rdData);
        end
    endtask

    task automatic t_rw;
        logic [7:0] d, e;
        for (int a = 7; a <= 17; a++) begin
            d = 8'h5A ^ a[7:0];
            host.wr(a[6:0], d);
            e = (a == 13 || a == 14) ? 8'h00 : (a == 15) ? ID : d;
            e = (a == 17) ? (d & 8'h0F) : e;
            host.rd(a[6:0], rdData);
            chk("readback", e, rdData);
        end
        chk("fields", {32'h52535051, 7'h26, 4'hB}, fld);
    endtask

    task automatic t_route;
        for (int i = 0; i < 8; i++) begin
            if (i == 6)
                continue;
            host.wr(7'h0C, 8'h01 << i);
            src <= ~(8'h01 << i);
            repeat (2) @(posedge clk);
            #1 chk("pin unrouted", 1'b0, intPin);
            @(posedge clk) src <= 8'h01 << i;
            repeat (2) @(posedge clk);
            #1 chk("pin routed", 1'b1, intPin);
            @(posedge clk) src <= 8'h00;
        end
    endtask

    task automatic t_gyro;
        for (int r = 0; r < 8; r++)
            for (int b = 0; b < 4; b++) begin
                host.wr(7'h10, {r[2:0], b[1:0], 1'b0, b[1:0]});
                gyrOn <= r[0];
                repeat (2) @(posedge clk);
                #1 chk("rate", TEN[r], tenths);
                chk("range", DPS[b], dps);
                chk("range valid", b != 2, rangeValid);
                chk("first cutoff", LP1[r], lp1);
                chk("second cutoff", LP2[r * 4 + b], lp2);
                chk("common rate", r[0] ? r[2:0] : 3'h0, commonRate);
                chk("common valid", r[0], rateOk);
            end
    endtask

    task automatic t_accel;
        host.wr(7'h07, 8'h10);
        host.wr(7'h08, 8'h10);
        host.wr(7'h0A, 8'h81);
        host.wr(7'h0C, 8'h40);
        axisEn <= 6'h02;
        smp(8'h20, 8'h00);
        chk("enter early", 1'b0, evtActive);
        smp(8'h20, 8'h00);
        chk("enter", 1'b1, evtActive);
        @(posedge clk);
        #1 chk("accel pin", 1'b1, intPin);
        smp(8'h05, 8'h00);
        chk("exit wait", 1'b1, evtActive);
        smp(8'h20, 8'h00);
        smp(8'h05, 8'h00);
        chk("count restart", 1'b1, evtActive);
        smp(8'h05, 8'h00);
        chk("exit", 1'b0, evtActive);
        host.wr(7'h0A, 8'h01);
        axisEn <= 6'h0A;
        combineAnd <= 1'b1;
        smp(8'h20, 8'h05);
        smp(8'h20, 8'h05);
        chk("and partial", 1'b0, evtActive);
        smp(8'h20, 8'h20);
        smp(8'h20, 8'h20);
        chk("and full", 1'b1, evtActive);
        @(posedge clk) combineAnd <= 1'b0;
        smp(8'h05, 8'h20);
        chk("or holds", 1'b1, evtActive);
        smp(8'h05, 8'h05);
        chk("no wait exit", 1'b0, evtActive);
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            err_total++;
            end_sim();
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        accOn <= 1'b1;
        t_reset();
        t_rw();
        t_route();
        t_gyro();
        t_accel();
        end_sim();
    end
endmodule
`default_nettype wire
